//--- vfxseq_defs.vh
// Constants for the vector floating-point exception sequencer
`ifndef VFXSEQ_DEFS_VH
`define VFXSEQ_DEFS_VH
`define VFX_CSR_RESET      16'h1f80
`define VFX_FLAG_LSB       0
`define VFX_DAZ_BIT        6
`define VFX_MASK_LSB       7
`define VFX_RC_LSB         13
`define VFX_FTZ_BIT        15
`define VFX_VALID_DAZ      32'h0000ffff
`define VFX_VALID_NODAZ    32'h0000ffbf
`define VFX_SAVE_MASK_BYTE 28
`define VFX_LEAF_FEATURES  32'h00000001
`define VFX_FEAT_SAVE_BIT  24
`define VFX_FEAT_GEN1_BIT  25
`define VFX_FEAT_GEN2_BIT  26
`define VFX_CR4_SAVE_BIT   9
`define VFX_CR4_FAULT_BIT  10
`define VFX_CR0_IMIT_BIT   2
`define VFX_PRE_SET        6'h07
`define VFX_POST_SET       6'h38
`endif

//--- vfxseq_lane_or.v
// Per-lane exception flag reduction into one flag set
`timescale 1ns/1ps
`default_nettype none
module vfxseq_lane_or #(
  parameter LANES = 4
) (
  input  wire [6*LANES-1:0] i_lane_flags,  // Six flags per lane
  output wire [5:0]         o_flags        // OR per condition type
);
  genvar g;
  // OR each condition across all lanes
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_or
      wire [LANES-1:0] col;
      genvar l;
      for (l = 0; l < LANES; l = l + 1) begin : g_l
        assign col[l] = i_lane_flags[6*l+g];
      end
      assign o_flags[g] = |col;
    end
  endgenerate
endmodule
`default_nettype wire

//--- vfxseq_top.v
// Vector floating-point exception sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "vfxseq_defs.vh"
// Sequencing overview
// An instruction is taken only while the sequencer is idle. Its per-lane
// conditions are captured at issue and reduced to one set per phase.
// Pre phase: invalid, denormal and divide-by-zero flags are ORed in; if
// any unmasked one is new, a fault pulse is raised and the sequencer
// parks until the handler returns. Post phase: overflow, underflow and
// inexact are treated the same way. The result write pulse is held back
// until both phases are clear or handled, so masked results never leave
// ahead of an unmasked fault.
// The fault is the vector fault when the OS has declared that it handles
// it, and the invalid-opcode fault otherwise. Faults never reach the
// legacy error pin, and the ignore-error pin has no say in any of this.
// Limitation: the conditions are sampled once at issue; a handler that
// fixes operands is seen only as its return pulse, so the post set
// captured at issue is reused after the pre handler returns.
// A return pulse outside a wait state is ignored, so a late handler
// cannot restart an instruction that has already completed.
// Capability outputs (identification word, save image mask, OS enables)
// are plain registered copies and need no sequencing; the init request
// touches none of them and leaves the control/status register alone.
module vfxseq_top #(
  parameter LANES       = 4,
  parameter HAS_DAZ     = 1,
  parameter HAS_IDENT   = 1,
  parameter HAS_GEN1    = 1,
  parameter HAS_GEN2    = 1,
  parameter HAS_SAVE    = 1
) (
  input  wire               i_clk_sys,       // Core clock
  input  wire               i_rst,           // Hardware reset, high
  input  wire               i_init,          // Init request, same clock
  input  wire               i_instr_start,   // Vector fp instruction issue
  input  wire               i_instr_gen2,    // Instruction is second gen
  input  wire [6*LANES-1:0] i_lane_pre,      // Per-lane pre conditions
  input  wire [6*LANES-1:0] i_lane_post,     // Per-lane post conditions
  input  wire               i_handler_return,// Fault handler returned
  input  wire               i_csr_wr,        // Write control/status reg
  input  wire [31:0]        i_csr_wdata,     // Value to write
  input  wire               i_ident_exec,    // Identification instr
  input  wire [31:0]        i_accum,         // Accumulator leaf value
  input  wire [31:0]        i_ctrl_reg_four, // Control register four
  input  wire               i_ignore_fp_error_in_pin, // Raw pin
  input  wire               i_legacy_fp_error, // Legacy unit error
  input  wire               i_native_fp_fault_report_bit, // Reg zero bit
  output reg                o_fp_error_out_pin, // Legacy error pin
  output reg                o_vector_fp_fault,  // Vector fault pulse
  output reg                o_invalid_opcode_fault, // Pulse
  output reg                o_general_protection_fault, // Pulse
  output reg                o_result_write,  // Result write pulse
  output reg                o_busy,          // Instruction in flight
  output reg                o_fault_phase_post, // Last fault was post
  output reg [31:0]         o_vector_control_status_reg, // CSR value
  output reg [1:0]          o_vector_round,  // Vector rounding field
  output reg [31:0]         o_vector_control_valid_bits, // Save image
  output reg [31:0]         o_ident_features, // Leaf 1 feature word
  output reg                o_ident_valid,   // Feature word valid
  output reg                o_os_state_save_enable, // Reg four bit 9
  output reg                o_os_vector_fault_enable // Reg four bit 10
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_WPRE = 3'h2;
  localparam ST_POST = 3'h3;
  localparam ST_WPST = 3'h4;
  localparam ST_DONE = 3'h5;

  // Condition sets; the bit index of a condition is its sticky flag bit.
  // Invalid, denormal and divide-by-zero are known before computing;
  // overflow, underflow and inexact only once a result exists.
  localparam [5:0] COND_PRE  = `VFX_PRE_SET;
  localparam [5:0] COND_POST = `VFX_POST_SET;

  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [5:0]  pend_pre;
  reg [5:0]  pend_post;
  reg        ign_s1;
  reg        ign_s2;
  wire [5:0] pre_or;
  wire [5:0] post_or;
  wire [5:0] masks;
  wire [5:0] unmasked_pre;
  wire [5:0] unmasked_post;
  wire       os_fault_ok;
  wire [31:0] valid_bits;
  wire [31:0] save_mask;
  reg  [31:0] next_csr;
  wire        csr_write_bad;
  wire        instr_unsup;
  wire        fault_now;

  // Nonzero when a write value sets a bit outside the supported set
  function bad_write;
    input [31:0] value;
    input [31:0] supported;
    begin
      bad_write = ((value & ~supported) != 32'h00000000);
    end
  endfunction

  // Set when the issued generation is not built into this device
  function gen_missing;
    input gen2;
    input has1;
    input has2;
    begin
      gen_missing = (gen2 && !has2) || (!gen2 && !has1);
    end
  endfunction

  // Reduce lanes into one condition set each phase
  vfxseq_lane_or #(.LANES(LANES)) u_pre_or (
    .i_lane_flags (i_lane_pre),
    .o_flags      (pre_or)
  );
  vfxseq_lane_or #(.LANES(LANES)) u_post_or (
    .i_lane_flags (i_lane_post),
    .o_flags      (post_or)
  );

  // Unmasked tests use only new conditions, never the sticky flags
  assign masks = o_vector_control_status_reg[`VFX_MASK_LSB+5:`VFX_MASK_LSB];
  assign unmasked_pre = pend_pre & ~masks & COND_PRE;
  assign unmasked_post = pend_post & ~masks & COND_POST;
  assign os_fault_ok = i_ctrl_reg_four[`VFX_CR4_FAULT_BIT];
  assign valid_bits = (HAS_DAZ != 0) ? `VFX_VALID_DAZ : `VFX_VALID_NODAZ;
  assign save_mask = (HAS_DAZ != 0) ? `VFX_VALID_DAZ : 32'h00000000;
  assign csr_write_bad = i_csr_wr && bad_write(i_csr_wdata, valid_bits);
  assign instr_unsup = gen_missing(i_instr_gen2, HAS_GEN1 != 0,
                                   HAS_GEN2 != 0);
  assign fault_now = (state == ST_PRE && unmasked_pre != 6'h00) ||
                     (state == ST_POST && unmasked_post != 6'h00);

  // Ignore pin is synchronised but deliberately feeds no vector logic.
  // It is kept so the pin has a defined load; wiring it into the fault
  // path would let the legacy unit's error handling suppress vector
  // faults, which the two units must never share.
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ign_s1 <= 1'b0;
      ign_s2 <= 1'b0;
    end else begin
      ign_s1 <= i_ignore_fp_error_in_pin;
      ign_s2 <= ign_s1;
    end
  end

  // Sequencer next state
  // Each phase takes one cycle when clean. A wait state is left only by a
  // handler return, so a slow handler simply stretches the instruction.
  // The post check always follows the pre phase, also after a pre fault,
  // which is what allows two faults for one instruction.
  // Done lasts one cycle and launches the result write.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_instr_start)
          next_state = ST_PRE;
      end
      ST_PRE: begin
        if (unmasked_pre != 6'h00)
          next_state = ST_WPRE;
        else
          next_state = ST_POST;
      end
      ST_WPRE: begin
        if (i_handler_return)
          next_state = ST_POST;
      end
      ST_POST: begin
        if (unmasked_post != 6'h00)
          next_state = ST_WPST;
        else
          next_state = ST_DONE;
      end
      ST_WPST: begin
        if (i_handler_return)
          next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer state, conditions latched at issue
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state     <= ST_IDLE;
      pend_pre  <= 6'h00;
      pend_post <= 6'h00;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && i_instr_start) begin
        pend_pre  <= pre_or & COND_PRE;
        pend_post <= post_or & COND_POST;
      end
    end
  end

  // Fault pulses, result write and status outputs
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_vector_fp_fault          <= 1'b0;
      o_invalid_opcode_fault     <= 1'b0;
      o_general_protection_fault <= 1'b0;
      o_result_write             <= 1'b0;
      o_busy                     <= 1'b0;
      o_fault_phase_post         <= 1'b0;
    end else begin
      o_vector_fp_fault          <= 1'b0;
      o_invalid_opcode_fault     <= 1'b0;
      o_general_protection_fault <= 1'b0;
      o_result_write             <= 1'b0;
      o_busy <= (next_state != ST_IDLE);
      // Unsupported generation raises invalid opcode at issue; the phases still run
      if (state == ST_IDLE && i_instr_start && instr_unsup)
        o_invalid_opcode_fault <= 1'b1;
      if (fault_now) begin
        o_fault_phase_post <= (state == ST_POST);
        if (os_fault_ok)
          o_vector_fp_fault <= 1'b1;
        else
          o_invalid_opcode_fault <= 1'b1;
      end
      // Masked results only leave once every fault has been handled
      if (state == ST_DONE)
        o_result_write <= 1'b1;
      // Reserved bit write, including unsupported denormal zeroing
      if (csr_write_bad)
        o_general_protection_fault <= 1'b1;
      if (i_ident_exec && HAS_IDENT == 0)
        o_invalid_opcode_fault <= 1'b1;
    end
  end

  // Next control/status value: a legal write first, then the phase flags.
  // Flags are ORed over the written value, so a condition raised in the
  // write cycle is never lost; a refused write leaves the flags alone.
  always @* begin
    next_csr = o_vector_control_status_reg;
    if (i_csr_wr && !csr_write_bad)
      next_csr = i_csr_wdata;
    if (state == ST_PRE)
      next_csr[5:0] = next_csr[5:0] | pend_pre;
    else if (state == ST_POST)
      next_csr[5:0] = next_csr[5:0] | pend_post;
  end

  // Control/status register: only hardware reset restores it, not init
  always @(posedge i_clk_sys) begin
    if (i_rst)
      o_vector_control_status_reg <= {16'h0000, `VFX_CSR_RESET};
    else
      o_vector_control_status_reg <= next_csr;
  end

  // Vector rounding comes only from the vector register.
  // The legacy control word has no path here; software that wants the
  // same rounding in both units must program both.
  always @(posedge i_clk_sys) begin
    if (i_rst)
      o_vector_round <= 2'b00;
    else
      o_vector_round <=
        o_vector_control_status_reg[`VFX_RC_LSB+1:`VFX_RC_LSB];
  end

  // Legacy error pin follows the legacy unit, held low while the native report bit is set.
  // No vector fault term is ORed in, whatever the native report bit says.
  always @(posedge i_clk_sys) begin
    if (i_rst)
      o_fp_error_out_pin <= 1'b0;
    else
      o_fp_error_out_pin <= i_legacy_fp_error &
                            !i_native_fp_fault_report_bit;
  end

  // Identification word; leaf 1 is the only leaf with feature bits
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ident_features <= 32'h00000000;
      o_ident_valid    <= 1'b0;
    end else begin
      o_ident_valid <= i_ident_exec && (HAS_IDENT != 0);
      if (i_ident_exec && HAS_IDENT != 0) begin
        o_ident_features <= 32'h00000000;
        if (i_accum == `VFX_LEAF_FEATURES) begin
          o_ident_features[`VFX_FEAT_GEN1_BIT] <=
            (HAS_GEN1 != 0);
          o_ident_features[`VFX_FEAT_GEN2_BIT] <=
            (HAS_GEN2 != 0);
          o_ident_features[`VFX_FEAT_SAVE_BIT] <=
            (HAS_SAVE != 0);
        end
      end
    end
  end

  // Capability mirrors; the OS bits are copied, never set by hardware
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_vector_control_valid_bits <= 32'h00000000;
      o_os_state_save_enable      <= 1'b0;
      o_os_vector_fault_enable    <= 1'b0;
    end else begin
      // Save image word at bytes 28..31; zero when no denormal zeroing
      o_vector_control_valid_bits <= save_mask;
      o_os_state_save_enable <=
        i_ctrl_reg_four[`VFX_CR4_SAVE_BIT];
      o_os_vector_fault_enable <=
        i_ctrl_reg_four[`VFX_CR4_FAULT_BIT];
    end
  end
endmodule
`default_nettype wire

//--- vfxseq_top_checker.sv
// Port-level assertions for the vector exception sequencer
`timescale 1ns/1ps
`default_nettype none
module vfxseq_top_checker #(
  parameter HAS_IDENT = 1,
  parameter HAS_GEN1  = 1,
  parameter HAS_GEN2  = 1,
  parameter HAS_SAVE  = 1
) (
  input wire logic        i_clk_sys, i_rst, i_instr_start, i_instr_gen2,
  input wire logic        i_handler_return, i_csr_wr, i_ident_exec,
  input wire logic        i_legacy_fp_error, i_native_fp_fault_report_bit,
  input wire logic [31:0] i_csr_wdata, i_accum, i_ctrl_reg_four,
  input wire logic        o_fp_error_out_pin, o_vector_fp_fault, o_busy,
  input wire logic        o_invalid_opcode_fault, o_general_protection_fault,
  input wire logic        o_result_write, o_fault_phase_post, o_ident_valid,
  input wire logic        o_os_state_save_enable, o_os_vector_fault_enable,
  input wire logic [31:0] o_vector_control_status_reg, o_ident_features,
  input wire logic [31:0] o_vector_control_valid_bits
);
  // A zero save image stands for the default mask with bit 6 reserved
  wire [31:0] legal = (o_vector_control_valid_bits == 32'h0) ?
                      32'h0000ffbf : o_vector_control_valid_bits;
  wire [2:0]  feat  = {HAS_GEN2 != 0, HAS_GEN1 != 0, HAS_SAVE != 0};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Steps of one instruction
  sequence s_take; i_instr_start && !o_busy; endsequence
  sequence s_ret_pre; i_handler_return && o_busy && !o_fault_phase_post;
  endsequence
  sequence s_ret_post; i_handler_return && o_busy && o_fault_phase_post;
  endsequence
  a_err_pin_legacy: assert property (
    !$past(i_rst) |-> o_fp_error_out_pin ==
      $past(i_legacy_fp_error && !i_native_fp_fault_report_bit))
    else $error("error pin not from legacy unit");
  a_os_flags_copy: assert property (
    !$past(i_rst) |-> {o_os_vector_fault_enable, o_os_state_save_enable}
      == $past(i_ctrl_reg_four[10:9])) else $error("os flags wrong");
  a_fault_os_gate: assert property (
    o_vector_fp_fault |-> o_os_vector_fault_enable)
    else $error("vector fault with os flag clear");
  a_pre_ret_post: assert property (
    s_ret_pre |-> ##[1:4] (o_vector_fp_fault || o_invalid_opcode_fault ||
      o_result_write)) else $error("no post step after return");
  a_post_ret_done: assert property (
    s_ret_post |-> ##[1:4] o_result_write) else $error("no completion");
  a_hold_result: assert property (
    o_vector_fp_fault |-> !o_result_write [*3])
    else $error("result written during fault");
  a_take_busy: assert property (
    s_take |=> o_busy) else $error("start not taken");
  a_csr_reset: assert property (
    $fell(i_rst) |-> o_vector_control_status_reg == 32'h00001f80)
    else $error("csr reset value wrong");
  a_reserved_gp: assert property (
    i_csr_wr && |(i_csr_wdata & ~legal) |=> o_general_protection_fault &&
      $stable(o_vector_control_status_reg)) else $error("reserved write");
  a_ident_leaf: assert property (
    i_ident_exec && i_accum == 32'h1 |=> (HAS_IDENT != 0) ? (o_ident_valid
      && o_ident_features[26:24] == feat) : o_invalid_opcode_fault)
    else $error("feature word wrong");
  a_unsup_gen: assert property (
    s_take ##0 (i_instr_gen2 && HAS_GEN2 == 0) |=> o_invalid_opcode_fault)
    else $error("unsupported instruction not refused");
endmodule
bind vfxseq_top vfxseq_top_checker #(.HAS_IDENT(HAS_IDENT),
  .HAS_GEN1(HAS_GEN1), .HAS_GEN2(HAS_GEN2), .HAS_SAVE(HAS_SAVE)) u_check (
  .i_clk_sys, .i_rst, .i_instr_start, .i_instr_gen2, .i_handler_return,
  .i_csr_wr, .i_ident_exec, .i_legacy_fp_error,
  .i_native_fp_fault_report_bit, .i_csr_wdata, .i_accum, .i_ctrl_reg_four,
  .o_fp_error_out_pin, .o_vector_fp_fault, .o_busy, .o_invalid_opcode_fault,
  .o_general_protection_fault, .o_result_write, .o_fault_phase_post,
  .o_ident_valid, .o_os_state_save_enable, .o_os_vector_fault_enable,
  .o_vector_control_status_reg, .o_ident_features,
  .o_vector_control_valid_bits);
`default_nettype wire

//--- vfxseq_handler_model.sv
// Fault handler stand-in: answers each fault with a return pulse
`timescale 1ns/1ps
`default_nettype none
module vfxseq_handler_model (
  input  wire logic       i_clk_sys,        // Core clock
  input  wire logic       i_rst,            // Reset, high
  input  wire logic       i_fault,          // Any fault pulse
  input  wire logic [3:0] i_delay,          // Handler run time
  output logic            o_handler_return  // Return pulse
);
  logic [3:0] cnt;
  logic       pend;
  // A slow handler keeps the instruction parked in its wait state
  always @(posedge i_clk_sys) begin
    o_handler_return <= 1'b0;
    if (i_rst) begin
      pend <= 1'b0;
      cnt  <= 4'h0;
    end else if (i_fault) begin
      pend <= 1'b1;
      cnt  <= i_delay;
    end else if (pend && cnt == 4'h0) begin
      pend             <= 1'b0;
      o_handler_return <= 1'b1;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- test_vfxseq_top.sv
// Self-checking bench for the vector exception sequencer
`timescale 1ns/1ps
`default_nettype none
module test_vfxseq_top;
  logic        clk, rst, init, start, gen2, cwr, iex, ign, leg, nat, ret;
  logic        vec, ud, gp, wr, busy, pin, phase, ivld, ph;
  logic [23:0] pre, post;
  logic [31:0] wd, acc, cr4, csr, vb, feat, fv;
  logic [3:0]  dly;
  logic [1:0]  rnd;
  int          num_errors = 0;
  int          checks = 0;
  int          ncyc;
  int          cnt[5] = '{default: 0};
  vfxseq_top #(.HAS_GEN2(0)) i_vfxseq_top (
    .i_clk_sys(clk), .i_rst(rst), .i_init(init), .i_instr_start(start),
    .i_instr_gen2(gen2), .i_lane_pre(pre), .i_lane_post(post),
    .i_handler_return(ret), .i_csr_wr(cwr), .i_csr_wdata(wd),
    .i_ident_exec(iex), .i_accum(acc), .i_ctrl_reg_four(cr4),
    .i_ignore_fp_error_in_pin(ign), .i_legacy_fp_error(leg),
    .i_native_fp_fault_report_bit(nat), .o_fp_error_out_pin(pin),
    .o_vector_fp_fault(vec), .o_invalid_opcode_fault(ud),
    .o_general_protection_fault(gp), .o_result_write(wr), .o_busy(busy),
    .o_fault_phase_post(phase), .o_vector_control_status_reg(csr),
    .o_vector_round(rnd), .o_vector_control_valid_bits(vb),
    .o_ident_features(feat), .o_ident_valid(ivld),
    .o_os_state_save_enable(), .o_os_vector_fault_enable());
  vfxseq_handler_model i_vfxseq_handler_model (.i_clk_sys(clk),
    .i_rst(rst), .i_fault(vec | ud), .i_delay(dly), .o_handler_return(ret));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulse counters; the phase of the first vector fault is kept per run
  always @(posedge clk) begin
    if (vec && cnt[0] == 0) ph = phase;
    if (ivld) fv = feat;
    cnt[0] += vec;
    cnt[1] += ud;
    cnt[2] += wr;
    cnt[3] += gp;
    cnt[4] += ivld;
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wcsr(input logic [31:0] v);
    cnt = '{default: 0};
    cwr = 1'b1;
    wd = v;
    tick;
    cwr = 1'b0;
    repeat (2) tick;
  endtask
  // One instruction; waits a bounded time for its result write
  task automatic run(input logic [23:0] p, q, input logic g,
                     input logic [3:0] d);
    pre = p;
    post = q;
    gen2 = g;
    dly = d;
    cnt = '{default: 0};
    start = 1'b1;
    tick;
    start = 1'b0;
    ncyc = 0;
    while (cnt[2] == 0 && ncyc < 300) begin
      tick;
      ncyc++;
    end
    repeat (2) tick;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, init, start, gen2, cwr, iex, ign, leg, nat} = 9'h100;
    {pre, post, wd, acc, dly} = '0;
    cr4 = 32'h00000600;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    check(csr, 32'h00001f80);
    tick;
    check(vb, 32'h0000ffff);
    acc = 32'h00000001;
    iex = 1'b1;
    tick;
    iex = 1'b0;
    repeat (2) tick;
    check(cnt[4], 1);
    check(fv & 32'h07000000, 32'h03000000);
    wcsr(32'h00007f80);
    check(rnd, 2'b11);
    wcsr(32'h00017f80);
    check(cnt[3], 1);
    check(csr, 32'h00007f80);
    init = 1'b1;
    tick;
    init = 1'b0;
    tick;
    check(csr, 32'h00007f80);
    wcsr(32'h00001f80);
    // All masked: lanes ORed, no fault, straight completion
    run(24'h080004, 24'h808000, 1'b0, 4'h0);
    check(ncyc, 4);
    check(cnt[0], 0);
    check(csr, 32'h00001fae);
    // Unmask with flags still sticky: old flags must not fault
    wcsr(32'h0000002e);
    run(24'h0, 24'h0, 1'b0, 4'h0);
    check(cnt[0], 0);
    ign = 1'b1;
    run(24'h000004, 24'h800000, 1'b0, 4'h6);
    check(cnt[0], 2);
    check(ph, 1'b0);
    check(cnt[2], 1);
    ign = 1'b0;
    cr4 = 32'h00000200;
    tick;
    run(24'h000001, 24'h0, 1'b0, 4'h1);
    check(cnt[1], 1);
    check(cnt[0], 0);
    cr4 = 32'h00000600;
    run(24'h0, 24'h0, 1'b1, 4'h0);
    check(cnt[1], 1);
    for (int k = 0; k < 4; k++) begin
      {leg, nat} = k[1:0];
      repeat (2) tick;
      check(pin, k == 2);
    end
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
